// >>> rtl/vt_adc_ctrl.sv
// control of the voltage/temperature sigma-delta converter and the shared decimation filter
//
// How it works
// (RULE1) enable bit powers converter; clear powers down
// (RULE2) excitation code drives sensor/ground current sources
// (RULE3) coding bit picks unipolar or twos complement
// (RULE4) input 00: battery, buffers on, voltage result
// (RULE5) inputs 01 and 10 write temperature result
// (RULE6) input 11 shorts input, voltage result
// (RULE7) reference select drives mux, ground per channel
// (RULE8) software keeps reserved bits as required
// (RULE9) changing filter register resets both converters
// (RULE10) chop on; zero averaging triples period
// (RULE11) chop: first result after two periods
// (RULE12) running average forced by chop, adds period
// (RULE13) averaging factor sets postfilter, lengthens period
// (RULE14) notch bit adds second sinc3 notch
// (RULE15) period is (factor+1)*64 modulator ticks
// (RULE16) factor 126 forces 60 Hz, 127 50 Hz
// (RULE17) nonzero averaging multiplies period by (3+factor)
// (RULE18) chop period (sf+1)*64*(3+af)+3 ticks
// (RULE19) low power runs modulator at 131 kHz
// (RULE20) software limits factor combinations and rates
// (RULE21) settling 3/4 plain, 1/2 with averaging
// (RULE22) 60 us startup before settling begins
`timescale 1ns/1ps
`default_nettype none

`include "vt_adc_ctrl_defines.svh"

module vt_adc_ctrl
  import vt_adc_ctrl_pkg::*;
#(
  parameter int STARTUP_CYCLES = `STARTUP_CYCLES
)
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [31:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic LOW_POWER_MODE,
  output vt_analog_t VT_ANALOG,
  output filter_cfg_t FILTER_CFG,
  output strobe_t STROBES,
  output logic MOD_TICK,
  output logic RESULT_SETTLED
);

  // ==========================================================
  // helpers

  // output period in modulator ticks
  function automatic logic [19:0] period_ticks(input logic [15:0] f);
    logic [19:0] base;
    logic [19:0] af3;
    logic [6:0] sf;
    logic [5:0] af;
    begin
      sf = f[`FLT_SF_HI:`FLT_SF_LO];
      af = f[`FLT_AF_HI:`FLT_AF_LO];
      base = (20'(sf) + 20'h00001) * 20'(`DECIM_BASE); // RULE15
      af3 = 20'(af) + 20'(`AF_OFFSET);
      if (sf == `SF_FORCE_60HZ)
      begin
        period_ticks = 20'(`MOD_CLK_HZ / `RATE_60HZ); // RULE16
      end
      else if (sf == `SF_FORCE_50HZ)
      begin
        period_ticks = 20'(`MOD_CLK_HZ / `RATE_50HZ); // RULE16
      end
      else if (f[`FLT_CHOP_BIT])
      begin
        // af of zero still multiplies by three here, which is the rate drop
        period_ticks = 20'(base * af3) + 20'(`CHOP_EXTRA_TICKS); // RULE10 RULE18
      end
      else if (af != 6'h00)
      begin
        period_ticks = 20'(base * af3); // RULE13 RULE17
      end
      else
      begin
        period_ticks = base; // RULE15
      end
    end
  endfunction

  // phases in which the modulator runs and ticks are counted
  function automatic logic converting(input phase_t p);
    begin
      converting = (p == PH_SETTLE) || (p == PH_RUN);
    end
  endfunction

  // running average is forced on while chopping
  function automatic logic ravg_on(input logic [15:0] f);
    begin
      ravg_on = f[`FLT_RAVG_BIT] | f[`FLT_CHOP_BIT]; // RULE12
    end
  endfunction

  // result register that a conversion on this input goes to: {voltage, temperature}
  function automatic logic [1:0] result_dest(input logic [1:0] sel);
    begin
      if ((sel == 2'b01) || (sel == 2'b10))
      begin
        result_dest = 2'b01; // RULE5
      end
      else
      begin
        result_dest = 2'b10; // RULE4 RULE6
      end
    end
  endfunction

  // read-only status word: phase, settle count, run and low power flags
  function automatic logic [15:0] status_word(input ctrl_state_t s);
    begin
      status_word = {11'h000, s.low_power, s.phase == PH_RUN, s.settle_left[1:0], 1'b0} | 16'(s.phase);
    end
  endfunction

  // settling length in output periods
  function automatic logic [2:0] settle_periods(input logic [15:0] f);
    logic ravg;
    begin
      ravg = ravg_on(f); // RULE12
      if (f[`FLT_CHOP_BIT])
      begin
        settle_periods = `SETTLE_CHOP; // RULE11
      end
      else if (f[`FLT_AF_HI:`FLT_AF_LO] != 6'h00)
      begin
        settle_periods = ravg ? `SETTLE_AVG_RAVG : `SETTLE_AVG; // RULE21
      end
      else
      begin
        settle_periods = ravg ? `SETTLE_PLAIN_RAVG : `SETTLE_PLAIN; // RULE12 RULE21
      end
    end
  endfunction

  // ==========================================================
  // state

  ctrl_state_t state;
  ctrl_state_t next_state;
  logic tick;
  logic period_end;
  logic [9:0] div_limit;
  logic filt_changed;
  logic [1:0] insel;
  logic [1:0] dest;

  always_comb
  begin
    // the slow oscillator only stretches the tick, so every count below stays valid
    div_limit = state.low_power ? 10'(`LP_TICK_CYCLES - 1) : 10'(`NORMAL_TICK_CYCLES - 1); // RULE19
    // at or past the limit: a switch back to the fast oscillator must not let the count run on and wrap
    tick = converting(state.phase) && (state.div_cnt >= div_limit);
    period_end = tick && (state.tick_cnt >= period_ticks(state.filt_ctrl) - 20'h00001);
    filt_changed = WR && (ADDR == `FILT_CTRL_ADDR) && (WDATA != state.filt_ctrl);
    insel = state.vt_ctrl[`VT_INSEL_HI:`VT_INSEL_LO];
    dest = result_dest(insel);
  end

  always_comb
  begin
    next_state = state;
    next_state.strobes = '0;

    // low power request from outside: counted once the last two stages agree
    next_state.lp_sync = {state.lp_sync[1:0], LOW_POWER_MODE};
    if (state.lp_sync[1] == state.lp_sync[2])
    begin
      next_state.low_power = state.lp_sync[2]; // RULE19
    end

    // register writes; reserved bits are stored as written
    if (WR && (ADDR == `VT_CTRL_ADDR))
    begin
      next_state.vt_ctrl = WDATA; // RULE8
    end
    if (WR && (ADDR == `FILT_CTRL_ADDR))
    begin
      next_state.filt_ctrl = WDATA;
    end

    // register reads, answered in the next cycle
    next_state.rdata = 16'h0000;
    if (RD)
    begin
      case (ADDR)
        `VT_CTRL_ADDR:
        begin
          next_state.rdata = state.vt_ctrl;
        end
        `FILT_CTRL_ADDR:
        begin
          next_state.rdata = state.filt_ctrl;
        end
        `STATUS_ADDR:
        begin
          next_state.rdata = status_word(state);
        end
        default:
        begin
          next_state.rdata = 16'h0000;
        end
      endcase
    end

    // modulator tick divider and output period counter
    if (tick)
    begin
      next_state.div_cnt = 10'h000;
      next_state.tick_cnt = period_end ? 20'h00000 : state.tick_cnt + 20'h00001;
    end
    else if (converting(state.phase))
    begin
      next_state.div_cnt = state.div_cnt + 10'h001;
    end

    // sequencing
    case (state.phase)
      PH_OFF:
      begin
        next_state.div_cnt = 10'h000;
        next_state.tick_cnt = 20'h00000;
        if (state.vt_ctrl[`VT_ENABLE_BIT])
        begin
          next_state.phase = PH_STARTUP; // RULE22
          next_state.startup_cnt = 13'h0000;
        end
      end
      PH_STARTUP:
      begin
        if (state.startup_cnt >= 13'(STARTUP_CYCLES - 1))
        begin
          next_state.phase = PH_SETTLE; // RULE22
          next_state.settle_left = settle_periods(state.filt_ctrl);
        end
        else
        begin
          next_state.startup_cnt = state.startup_cnt + 13'h0001;
        end
      end
      PH_SETTLE:
      begin
        if (period_end)
        begin
          if (state.settle_left <= 3'h1)
          begin
            next_state.phase = PH_RUN; // RULE11 RULE21
            next_state.settle_left = 3'h0;
            next_state.strobes.voltage_result_we = dest[1]; // RULE4 RULE6
            next_state.strobes.temperature_result_we = dest[0]; // RULE5
          end
          else
          begin
            next_state.settle_left = state.settle_left - 3'h1;
          end
        end
      end
      PH_RUN:
      begin
        if (period_end)
        begin
          next_state.strobes.voltage_result_we = dest[1]; // RULE4 RULE6
          next_state.strobes.temperature_result_we = dest[0]; // RULE5
        end
      end
      default:
      begin
        next_state.phase = PH_OFF;
      end
    endcase

    // a changed filter restarts both converters from the start of settling
    if (filt_changed)
    begin
      next_state.strobes.converter_reset = 1'b1; // RULE9
      next_state.strobes.voltage_result_we = 1'b0;
      next_state.strobes.temperature_result_we = 1'b0;
      next_state.div_cnt = 10'h000;
      next_state.tick_cnt = 20'h00000;
      // startup is not repeated: only the filter has to settle again
      if (converting(state.phase))
      begin
        next_state.phase = PH_SETTLE; // RULE9
        next_state.settle_left = settle_periods(WDATA);
      end
    end

    // power down wins over sequencing and the result strobes; the converter reset strobe still fires
    if (!state.vt_ctrl[`VT_ENABLE_BIT])
    begin
      next_state.phase = PH_OFF; // RULE1
      next_state.settle_left = 3'h0;
      next_state.strobes.voltage_result_we = 1'b0;
      next_state.strobes.temperature_result_we = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      state <= '0;
      state.vt_ctrl <= `VT_CTRL_RESET;
      state.filt_ctrl <= `FILT_CTRL_RESET;
      state.phase <= PH_OFF;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================
  // outputs

  always_comb
  begin
    VT_ANALOG.power_en = state.vt_ctrl[`VT_ENABLE_BIT]; // RULE1
    VT_ANALOG.exc_temperature_input_pin_en = state.vt_ctrl[`VT_EXC_LO]; // RULE2
    VT_ANALOG.exc_switched_ground_pin_en = state.vt_ctrl[`VT_EXC_HI]; // RULE2
    VT_ANALOG.unipolar = state.vt_ctrl[`VT_CODING_BIT]; // RULE3
    VT_ANALOG.input_select = insel; // RULE6
    VT_ANALOG.hv_buffer_en = state.vt_ctrl[`VT_ENABLE_BIT] && (insel == 2'b00); // RULE4
    VT_ANALOG.ref_select = state.vt_ctrl[`VT_REFSEL_HI:`VT_REFSEL_LO]; // RULE7
    // halved supply reference takes the switched ground only for temperature inputs
    VT_ANALOG.ref_ground_switched = (state.vt_ctrl[`VT_REFSEL_HI:`VT_REFSEL_LO] == 2'b11)
      && (dest == 2'b01); // RULE7
    FILTER_CFG.chop_en = state.filt_ctrl[`FLT_CHOP_BIT]; // RULE10
    FILTER_CFG.running_average_en = ravg_on(state.filt_ctrl); // RULE12
    FILTER_CFG.averaging_factor = state.filt_ctrl[`FLT_AF_HI:`FLT_AF_LO]; // RULE13
    FILTER_CFG.second_notch_en = state.filt_ctrl[`FLT_NOTCH_BIT]; // RULE14
    FILTER_CFG.decimation_factor = state.filt_ctrl[`FLT_SF_HI:`FLT_SF_LO]; // RULE15
    STROBES = state.strobes;
    MOD_TICK = tick;
    RESULT_SETTLED = (state.phase == PH_RUN);
    RDATA = state.rdata;
  end

endmodule

`default_nettype wire

// >>> rtl/vt_adc_ctrl_defines.svh
// register offsets, field positions, reset values and timing counts of the v/t converter control
`ifndef VT_ADC_CTRL_DEFINES_SVH
`define VT_ADC_CTRL_DEFINES_SVH

// ==========================================================
// register map
`define VT_CTRL_ADDR 32'hFFFF0510
`define FILT_CTRL_ADDR 32'hFFFF0518
`define STATUS_ADDR 32'hFFFF0520
`define VT_CTRL_RESET 16'h0000
`define FILT_CTRL_RESET 16'h0007

// ==========================================================
// channel control fields
`define VT_ENABLE_BIT 15
`define VT_EXC_HI 14
`define VT_EXC_LO 13
`define VT_CODING_BIT 9
`define VT_INSEL_HI 7
`define VT_INSEL_LO 6
`define VT_REFSEL_HI 5
`define VT_REFSEL_LO 4

// ==========================================================
// filter control fields
`define FLT_CHOP_BIT 15
`define FLT_RAVG_BIT 14
`define FLT_AF_HI 13
`define FLT_AF_LO 8
`define FLT_NOTCH_BIT 7
`define FLT_SF_HI 6
`define FLT_SF_LO 0

// ==========================================================
// timing
`define CORE_CLK_HZ 125000000
`define CORE_CLK_PERIOD_NS 8
`define MOD_CLK_HZ 512000
`define LP_CLK_HZ 131000
`define NORMAL_TICK_CYCLES (`CORE_CLK_HZ / `MOD_CLK_HZ)
`define LP_TICK_CYCLES (`CORE_CLK_HZ / `LP_CLK_HZ)
`define STARTUP_TIME_NS 60000
`define STARTUP_CYCLES ((`STARTUP_TIME_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define DECIM_BASE 64
`define AF_OFFSET 3
`define CHOP_EXTRA_TICKS 3
`define SF_FORCE_60HZ 7'h7E
`define SF_FORCE_50HZ 7'h7F
`define RATE_60HZ 60
`define RATE_50HZ 50
`define SETTLE_CHOP 3'h2
`define SETTLE_PLAIN 3'h3
`define SETTLE_PLAIN_RAVG 3'h4
`define SETTLE_AVG 3'h1
`define SETTLE_AVG_RAVG 3'h2

`endif

// >>> rtl/vt_adc_ctrl_pkg.sv
// types shared by the v/t converter control and its bench
package vt_adc_ctrl_pkg;

  // ==========================================================
  // sequencing
  typedef enum logic [1:0] {PH_OFF, PH_STARTUP, PH_SETTLE, PH_RUN} phase_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic power_en;
    logic exc_temperature_input_pin_en;
    logic exc_switched_ground_pin_en;
    logic unipolar;
    logic [1:0] input_select;
    logic hv_buffer_en;
    logic [1:0] ref_select;
    logic ref_ground_switched;
  } vt_analog_t;

  typedef struct packed {
    logic chop_en;
    logic running_average_en;
    logic [5:0] averaging_factor;
    logic second_notch_en;
    logic [6:0] decimation_factor;
  } filter_cfg_t;

  typedef struct packed {
    logic voltage_result_we;
    logic temperature_result_we;
    logic converter_reset;
  } strobe_t;

  typedef struct packed {
    logic [15:0] vt_ctrl;
    logic [15:0] filt_ctrl;
    logic [15:0] rdata;
    logic [2:0] lp_sync;
    logic low_power;
    logic [9:0] div_cnt;
    logic [19:0] tick_cnt;
    logic [2:0] settle_left;
    logic [12:0] startup_cnt;
    phase_t phase;
    strobe_t strobes;
  } ctrl_state_t;

endpackage

// >>> testbench/vt_adc_ctrl_assertions.sv
// port checker of the v/t converter control
`timescale 1ns/1ps
`default_nettype none
`include "vt_adc_ctrl_defines.svh"
// ==========================================================
// checker
module vt_adc_ctrl_assertions
  import vt_adc_ctrl_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [31:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic LOW_POWER_MODE,
  input wire vt_analog_t VT_ANALOG,
  input wire filter_cfg_t FILTER_CFG,
  input wire strobe_t STROBES,
  input wire logic MOD_TICK,
  input wire logic RESULT_SETTLED
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  sequence vt_write;
    WR && ADDR == `VT_CTRL_ADDR;
  endsequence
  // any field that differs from the present setting is a real change, except the running average bit while chopping
  sequence filt_change;
    WR && ADDR == `FILT_CTRL_ADDR && (WDATA[15] != FILTER_CFG.chop_en
      || WDATA[13:0] != {FILTER_CFG.averaging_factor, FILTER_CFG.second_notch_en, FILTER_CFG.decimation_factor}
      || (!FILTER_CFG.chop_en && WDATA[14] != FILTER_CFG.running_average_en));
  endsequence
  AST_POWER: assert property (vt_write |=> VT_ANALOG.power_en == $past(WDATA[15]))
    else $error("power enable not taken from write");
  AST_EXC: assert property (vt_write |=> {VT_ANALOG.exc_switched_ground_pin_en,
    VT_ANALOG.exc_temperature_input_pin_en} == $past(WDATA[14:13]))
    else $error("excitation enables wrong");
  AST_CODING: assert property (vt_write |=> VT_ANALOG.unipolar == $past(WDATA[9]))
    else $error("coding bit wrong");
  AST_HV_BUF: assert property (vt_write |=> VT_ANALOG.hv_buffer_en ==
    ($past(WDATA[15]) && $past(WDATA[7:6]) == 2'h0))
    else $error("buffer enable wrong");
  // a strobe is registered from the selection of the cycle before it
  AST_TEMP_DEST: assert property (STROBES.temperature_result_we |->
    $past(VT_ANALOG.input_select) inside {2'h1, 2'h2})
    else $error("temperature result on wrong input");
  AST_VOLT_DEST: assert property (STROBES.voltage_result_we |->
    $past(VT_ANALOG.input_select) inside {2'h0, 2'h3})
    else $error("voltage result on wrong input");
  AST_REF: assert property (vt_write |=> VT_ANALOG.ref_select == $past(WDATA[5:4]))
    else $error("reference select wrong");
  AST_FILT_RESET: assert property (filt_change |=> STROBES.converter_reset)
    else $error("no converter reset after filter change");
  AST_RESTART: assert property (filt_change |=> !RESULT_SETTLED)
    else $error("settling not restarted after filter change");
  AST_RAVG_FORCED: assert property (FILTER_CFG.chop_en |-> FILTER_CFG.running_average_en)
    else $error("running average not forced");
  AST_OFF_QUIET: assert property (!VT_ANALOG.power_en && !$past(VT_ANALOG.power_en)
    |-> !STROBES.voltage_result_we && !STROBES.temperature_result_we)
    else $error("result while powered down");
  AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside read answer");
endmodule
bind vt_adc_ctrl vt_adc_ctrl_assertions u_vt_adc_ctrl_assertions (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LOW_POWER_MODE(LOW_POWER_MODE), .VT_ANALOG(VT_ANALOG),
  .FILTER_CFG(FILTER_CFG), .STROBES(STROBES), .MOD_TICK(MOD_TICK), .RESULT_SETTLED(RESULT_SETTLED));
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench of the v/t converter control
`timescale 1ns/1ps
`default_nettype none
`include "vt_adc_ctrl_defines.svh"
// ==========================================================
// bench
module testbench
  import vt_adc_ctrl_pkg::*;
;
  logic CORE_CLK, RST, WR, RD, LOW_POWER_MODE, MOD_TICK, RESULT_SETTLED;
  logic [31:0] ADDR;
  logic [15:0] WDATA, RDATA, d;
  vt_analog_t VT_ANALOG;
  filter_cfg_t FILTER_CFG;
  strobe_t STROBES;
  int n_errors = 0;
  int cmp_count = 0;
  int n;
  logic [15:0] row_w [6] = '{16'h8000, 16'hA250, 16'hC0B0, 16'h60F0, 16'h8020, 16'h0000};
  vt_analog_t row_a [6] = '{10'b1000001000, 10'b1101010010, 10'b1010100111, 10'b0110110110, 10'b1000001100,
    10'h000};
  // short startup keeps the run small
  vt_adc_ctrl #(.STARTUP_CYCLES(20)) u_vt_adc_ctrl (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .LOW_POWER_MODE(LOW_POWER_MODE), .VT_ANALOG(VT_ANALOG),
    .FILTER_CFG(FILTER_CFG), .STROBES(STROBES), .MOD_TICK(MOD_TICK), .RESULT_SETTLED(RESULT_SETTLED));
  initial
  begin
    CORE_CLK = 1'b0;
    forever #4 CORE_CLK = ~CORE_CLK;
  end
  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] v);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a, output logic [15:0] v);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1;
    v = RDATA;
  endtask
  // bounded wait: sel 0 for a tick, 1 for a result strobe
  task automatic wait_sig(input int sel, output int c);
    c = 0;
    while ((sel ? (STROBES.voltage_result_we | STROBES.temperature_result_we) : MOD_TICK) !== 1'b1 && c < 60000)
    begin
      @(posedge CORE_CLK);
      #1;
      c++;
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge CORE_CLK);
    n_errors++;
    report_and_stop;
  end
  // ==========================================================
  // tests
  initial
  begin
    {ADDR, WDATA, WR, RD, LOW_POWER_MODE} = '0;
    RST = 1'b1;
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'b0;
    #1;
    chk("filter_cfg", `FILT_CTRL_RESET, FILTER_CFG);
    rd(`VT_CTRL_ADDR, d);
    chk("vt_reset", `VT_CTRL_RESET, d);
    rd(`FILT_CTRL_ADDR, d);
    chk("filt_reset", `FILT_CTRL_RESET, d);
    wr(32'hFFFF0514, 16'hFFFF);
    rd(32'hFFFF0514, d);
    chk("unmapped", 16'h0000, d);
    for (int i = 0; i < 6; i++)
    begin
      wr(`VT_CTRL_ADDR, row_w[i]);
      chk("vt_analog", 16'(row_a[i]), 16'(VT_ANALOG));
      rd(`VT_CTRL_ADDR, d);
      chk("vt_readback", row_w[i], d);
    end
    wr(`FILT_CTRL_ADDR, 16'h0000);
    chk("conv_reset", 16'h0001, 16'(STROBES));
    wr(`VT_CTRL_ADDR, 16'h8000);
    wait_sig(1, n);
    // 20 startup cycles and the enable cycle, then three periods of 64 ticks
    chk("settle_time", 16'h0001, 16'(n == 21 + `SETTLE_PLAIN * `DECIM_BASE * `NORMAL_TICK_CYCLES));
    chk("volt_dest", 16'h0004, 16'(STROBES));
    chk("settled", 16'h0001, 16'(RESULT_SETTLED));
    wr(`VT_CTRL_ADDR, 16'h8040);
    wait_sig(1, n);
    chk("period", 16'd15616, 16'(n + 2));
    chk("temp_dest", 16'h0002, 16'(STROBES));
    rd(`STATUS_ADDR, d);
    chk("status", 16'h000B, d);
    wait_sig(0, n);
    @(posedge CORE_CLK);
    #1;
    wait_sig(0, n);
    chk("tick_gap", `NORMAL_TICK_CYCLES, 16'(n + 1));
    @(posedge CORE_CLK);
    LOW_POWER_MODE <= 1'b1;
    repeat (2000) @(posedge CORE_CLK);
    #1;
    wait_sig(0, n);
    @(posedge CORE_CLK);
    #1;
    wait_sig(0, n);
    chk("lp_tick_gap", `LP_TICK_CYCLES, 16'(n + 1));
    wr(`FILT_CTRL_ADDR, 16'h0000);
    chk("same_write", 16'h0000, 16'(STROBES.converter_reset));
    wr(`FILT_CTRL_ADDR, 16'h8A85);
    chk("conv_reset2", 16'h0001, 16'(STROBES.converter_reset));
    chk("filter_cfg2", 16'hCA85, FILTER_CFG);
    @(posedge CORE_CLK);
    #1;
    chk("restart", 16'h0000, 16'(RESULT_SETTLED));
    @(posedge CORE_CLK);
    RST <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'b0;
    #1;
    chk("filter_cfg_rst", `FILT_CTRL_RESET, FILTER_CFG);
    chk("vt_analog_rst", 16'h0000, 16'(VT_ANALOG));
    chk("settled_rst", 16'h0000, 16'(RESULT_SETTLED));
    report_and_stop;
  end
endmodule
`default_nettype wire
